// ===== cesc_defines.vh
// register offsets, reset values, reserved and select codes and timing counts for the stimulus config bank
`ifndef CESC_DEFINES_VH
`define CESC_DEFINES_VH

`define CESC_ADDR_STIM2_DIVIDER_RATIO      8'h38
`define CESC_ADDR_S3_TIMING     8'h39
`define CESC_ADDR_S3_RESPONSE   8'h3a

`define CESC_RST_STIM2_DIVIDER_RATIO       8'h00
`define CESC_RST_S3_TIMING      8'h00
`define CESC_RST_S3_RESPONSE    8'h00

`define CESC_RATIO_RSVD         3'h7
`define CESC_MAG_RSVD           4'hf

`define CESC_SEL_DIV_DP         4'h6
`define CESC_SEL_DIV_DM         4'h9
`define CESC_SEL_DIV_BOTH       4'hc

`define CESC_CLK_MHZ            125
`define CESC_CYC_PER_MS         (`CESC_CLK_MHZ * 1000)

`endif

// ===== cesc_timer_lut.v
// response timer: decodes the three-bit duration code and counts it down
`timescale 1ns/1ps
`default_nettype none
`include "cesc_defines.vh"

module cesc_timer_lut
#(
    parameter CYC_PER_MS = `CESC_CYC_PER_MS
)
(
    input  wire        clk,
    input  wire        rst_n,
    input  wire        start,
    input  wire [2:0]  code,
    output reg         busy
);

    reg [23:0] count;

    // -----------------------------------------------------------------
    // duration decode
    // -----------------------------------------------------------------
    function [6:0] ms_of;
        input [2:0] c;
        begin
            case (c)
                3'h0:    ms_of = 7'd0;
                3'h1:    ms_of = 7'd1;
                3'h2:    ms_of = 7'd5;
                3'h3:    ms_of = 7'd10;
                3'h4:    ms_of = 7'd20;
                3'h5:    ms_of = 7'd40;
                3'h6:    ms_of = 7'd80;
                default: ms_of = 7'd100;
            endcase
        end
    endfunction

    wire [31:0] load_val = ms_of(code) * CYC_PER_MS;

    // load on start, count to zero
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= 24'h000000;
            busy  <= 1'b0;
        end
        else if (start)
        begin
            count <= load_val[23:0]; // R6
            busy  <= (load_val != 32'h00000000);
        end
        else if (count > 24'h000001)
        begin
            count <= count - 24'h000001;
        end
        else
        begin
            count <= 24'h000000;
            busy  <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== cesc_stim_config.v
// preloaded stimulus 2/3 configuration bank with response engine
//
// Contract
// R1 - register 0x38 reads zero in bits 7 to 3.
// R2 - the divider ratio is applied only for stimulus 2 select codes 0110b, 1001b or 1100b.
// R3 - ratio codes 000..110 map 0.25..0.66 and code 111 is reserved.
// R4 - the ratio field is not updated while a BC1.2 charging profile is active.
// R5 - with timer kind 1 the response is applied at once, held for the timer, then removed if the stimulus is gone.
// R6 - timer codes map 0, 1, 5, 10, 20, 40, 80 and 100 ms.
// R7 - a reserved code loaded into a field is rejected and the old value kept.
// R8 - the response magnitude sits in bits 7 to 4 and its meaning follows the select nibble.
// R9 - for voltage selects magnitude 0000 is pull-down, 0001..0100 are 400 mV, rising to 2200 mV, 1111 reserved.
// R10 - for resistor selects the magnitude is a resistor from 1.8 kohm to 150 kohm.
// R11 - for divider selects the magnitude is the minimum divider total, 93/100/125/150 kohm or 200 kohm.
// R12 - with usage 000b and no prior response a line keeps its 15 kohm reset pull-down, else prior response stays or pull-down goes.
// R13 - the magnitude is a four-bit field in the upper bits of the response register.
// R14 - every implemented field powers up zero and software writes do not change it.
`timescale 1ns/1ps
`default_nettype none
`include "cesc_defines.vh"

module cesc_stim_config
#(
    parameter CYC_PER_MS = `CESC_CYC_PER_MS
)
(
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire [7:0]  rd_addr,
    output reg  [7:0]  rd_data,
    input  wire        profile_load,
    input  wire        profile_bc12,
    input  wire [3:0]  stim2_response_select,
    input  wire [2:0]  load_ratio,
    input  wire        load_timer_kind,
    input  wire [2:0]  load_time,
    input  wire [2:0]  load_usage,
    input  wire [3:0]  load_select,
    input  wire [3:0]  load_magnitude,
    input  wire        detect_usage_a_event,
    input  wire        detect_usage_a_present,
    output reg  [2:0]  ratio_out,
    output reg         ratio_valid,
    output reg  [1:0]  resp_kind,
    output reg  [7:0]  resp_value,
    output reg         port_dplus_line,
    output reg         port_dminus_line,
    output reg         port_dplus_pulldown,
    output reg         port_dminus_pulldown
);

    // -----------------------------------------------------------------
    // reset synchroniser and pin syncs
    // -----------------------------------------------------------------
    reg  [1:0] rst_sync;
    wire       rst_n = rst_sync[1];
    reg  [1:0] ev_sync;
    reg  [1:0] pr_sync;
    reg        ev_prev;

    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_sync <= 2'h0;
            pr_sync <= 2'h0;
            ev_prev <= 1'b0;
        end
        else
        begin
            ev_sync <= {ev_sync[0], detect_usage_a_event};
            pr_sync <= {pr_sync[0], detect_usage_a_present};
            ev_prev <= ev_sync[1];
        end
    end

    wire ev_rise = ev_sync[1] & ~ev_prev;

    // -----------------------------------------------------------------
    // field storage, loaded only by the profile engine
    // -----------------------------------------------------------------
    reg [2:0] stim2_divider_ratio;
    reg       detect_usage_a_timer_kind;
    reg [2:0] detect_usage_a_response_time;
    reg [2:0] detect_usage_a;
    reg [3:0] detect_usage_a_response_select;
    reg [3:0] detect_usage_a_response_magnitude;

    function is_div;
        input [3:0] s;
        begin
            is_div = (s == `CESC_SEL_DIV_DP) || (s == `CESC_SEL_DIV_DM) ||
                     (s == `CESC_SEL_DIV_BOTH);
        end
    endfunction

    function sel_rsvd;
        input [3:0] s;
        begin
            sel_rsvd = (s == 4'h5) || (s == 4'h8) || (s == 4'hb);
        end
    endfunction

    // fields reset to zero; no software write path exists
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stim2_divider_ratio      <= 3'h0; // R14
            detect_usage_a_timer_kind         <= 1'b0;
            detect_usage_a_response_time      <= 3'h0;
            detect_usage_a           <= 3'h0;
            detect_usage_a_response_select    <= 4'h0;
            detect_usage_a_response_magnitude <= 4'h0;
        end
        else if (profile_load)
        begin
            if (!profile_bc12 && load_ratio != `CESC_RATIO_RSVD) // R4 R7
                stim2_divider_ratio <= load_ratio;
            detect_usage_a_timer_kind    <= load_timer_kind;
            detect_usage_a_response_time <= load_time;
            if (load_usage != 3'h4 && load_usage != 3'h5) // R7
                detect_usage_a <= load_usage;
            if (!sel_rsvd(load_select)) // R7
                detect_usage_a_response_select <= load_select;
            if (load_magnitude != `CESC_MAG_RSVD) // R7
                detect_usage_a_response_magnitude <= load_magnitude;
        end
    end

    // -----------------------------------------------------------------
    // magnitude decode: kind 0 mV/100, 1 resistor kohm, 2 divider kohm
    // -----------------------------------------------------------------
    function [9:0] decode_mag;
        input [3:0] s;
        input [3:0] m;
        begin
            if (s <= 4'h3)
            begin
                case (m) // R9
                    4'h0:    decode_mag = {2'd0, 8'd0};
                    4'h1, 4'h2, 4'h3, 4'h4: decode_mag = {2'd0, 8'd4};
                    4'h5:    decode_mag = {2'd0, 8'd5};
                    4'h6:    decode_mag = {2'd0, 8'd6};
                    4'h7:    decode_mag = {2'd0, 8'd7};
                    4'h8:    decode_mag = {2'd0, 8'd8};
                    4'h9:    decode_mag = {2'd0, 8'd9};
                    4'ha:    decode_mag = {2'd0, 8'd14};
                    4'hb:    decode_mag = {2'd0, 8'd16};
                    4'hc:    decode_mag = {2'd0, 8'd18};
                    4'hd:    decode_mag = {2'd0, 8'd20};
                    default: decode_mag = {2'd0, 8'd22};
                endcase
            end
            else if (is_div(s))
            begin
                case (m[2:0]) // R11
                    3'h0:    decode_mag = {2'd2, 8'd93};
                    3'h1:    decode_mag = {2'd2, 8'd100};
                    3'h2:    decode_mag = {2'd2, 8'd125};
                    3'h3:    decode_mag = {2'd2, 8'd150};
                    default: decode_mag = {2'd2, 8'd200};
                endcase
                if (m >= 4'hc)
                    decode_mag = {2'd2, 8'd200};
            end
            else
            begin
                case (m) // R10, in kohm except code 0 (1.8k)
                    4'h0:    decode_mag = {2'd1, 8'd2};
                    4'h1:    decode_mag = {2'd1, 8'd10};
                    4'h2:    decode_mag = {2'd1, 8'd15};
                    4'h3:    decode_mag = {2'd1, 8'd20};
                    4'h4:    decode_mag = {2'd1, 8'd25};
                    4'h5:    decode_mag = {2'd1, 8'd30};
                    4'h6:    decode_mag = {2'd1, 8'd40};
                    4'h7:    decode_mag = {2'd1, 8'd43};
                    4'h8:    decode_mag = {2'd1, 8'd50};
                    4'h9:    decode_mag = {2'd1, 8'd60};
                    4'ha:    decode_mag = {2'd1, 8'd75};
                    4'hb:    decode_mag = {2'd1, 8'd80};
                    4'hc:    decode_mag = {2'd1, 8'd100};
                    4'hd:    decode_mag = {2'd1, 8'd120};
                    default: decode_mag = {2'd1, 8'd150};
                endcase
            end
        end
    endfunction

    wire [9:0] mag_dec = decode_mag(detect_usage_a_response_select, detect_usage_a_response_magnitude); // R8

    // -----------------------------------------------------------------
    // response timer and line engine
    // -----------------------------------------------------------------
    wire timer_busy;
    reg  applied;
    reg  dp_touched;
    reg  dm_touched;

    cesc_timer_lut #(.CYC_PER_MS(CYC_PER_MS)) u_timer
    (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .start (ev_rise),
        .code  (detect_usage_a_response_time),
        .busy  (timer_busy)
    );

    wire dp_hit = (detect_usage_a_response_select == 4'h1) || (detect_usage_a_response_select == 4'h3) ||
                  (detect_usage_a_response_select == 4'h4) || (detect_usage_a_response_select == 4'h6) ||
                  (detect_usage_a_response_select == 4'ha) || (detect_usage_a_response_select == 4'hc) ||
                  (detect_usage_a_response_select == 4'hd);
    wire dm_hit = (detect_usage_a_response_select == 4'h2) || (detect_usage_a_response_select == 4'h3) ||
                  (detect_usage_a_response_select == 4'h7) || (detect_usage_a_response_select == 4'h9) ||
                  (detect_usage_a_response_select == 4'ha) || (detect_usage_a_response_select == 4'hc) ||
                  (detect_usage_a_response_select == 4'hd);
    wire keep_sel = (detect_usage_a_response_select == 4'he) || (detect_usage_a_response_select == 4'hf);

    // apply on event with timer kind 1, hold during timer, drop when stimulus gone
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            applied              <= 1'b0;
            dp_touched           <= 1'b0;
            dm_touched           <= 1'b0;
            port_dplus_line      <= 1'b0;
            port_dminus_line     <= 1'b0;
            port_dplus_pulldown  <= 1'b1;
            port_dminus_pulldown <= 1'b1;
        end
        else
        begin
            if (ev_rise && detect_usage_a_timer_kind) // R5
            begin
                applied <= 1'b1;
                if (detect_usage_a_response_select == 4'h0)
                begin
                    port_dplus_line  <= 1'b0;
                    port_dminus_line <= 1'b0;
                end
                else if (!keep_sel)
                begin
                    port_dplus_line  <= port_dplus_line | dp_hit;
                    port_dminus_line <= port_dminus_line | dm_hit;
                    dp_touched       <= dp_touched | dp_hit;
                    dm_touched       <= dm_touched | dm_hit;
                end
                // reset pull-downs stay with usage 000 and untouched line, or with select 1110/1111 unless usage is 111
                if (!(detect_usage_a == 3'h0 && !(dp_touched | dp_hit)) &&
                    !(keep_sel && detect_usage_a != 3'h7)) // R12
                    port_dplus_pulldown <= 1'b0;
                if (!(detect_usage_a == 3'h0 && !(dm_touched | dm_hit)) &&
                    !(keep_sel && detect_usage_a != 3'h7)) // R12
                    port_dminus_pulldown <= 1'b0;
            end
            else if (applied && !timer_busy && !ev_rise && !pr_sync[1]) // R5
            begin
                applied          <= 1'b0;
                port_dplus_line  <= 1'b0;
                port_dminus_line <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // decoded outputs and register read
    // -----------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ratio_out   <= 3'h0;
            ratio_valid <= 1'b0;
            resp_kind   <= 2'h0;
            resp_value  <= 8'h00;
            rd_data     <= 8'h00;
        end
        else
        begin
            ratio_out   <= stim2_divider_ratio; // R3
            ratio_valid <= is_div(stim2_response_select) && !profile_bc12; // R2
            resp_kind   <= mag_dec[9:8];
            resp_value  <= mag_dec[7:0];
            case (rd_addr)
                `CESC_ADDR_STIM2_DIVIDER_RATIO:
                    rd_data <= {5'h00, stim2_divider_ratio}; // R1
                `CESC_ADDR_S3_TIMING:
                    rd_data <= {1'b0, detect_usage_a_timer_kind, detect_usage_a_response_time, detect_usage_a};
                `CESC_ADDR_S3_RESPONSE:
                    rd_data <= {detect_usage_a_response_magnitude, detect_usage_a_response_select}; // R13
                default:
                    rd_data <= 8'h00;
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== cesc_stim_config_assertions.sv
// port checker for the stimulus config bank
`timescale 1ns/1ps
`default_nettype none
module cesc_stim_config_assertions
#(
    parameter CYC_PER_MS = 10
)
(
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic       profile_bc12,
    input wire logic [3:0] stim2_response_select,
    input wire logic       detect_usage_a_event,
    input wire logic [2:0] ratio_out,
    input wire logic       ratio_valid,
    input wire logic [1:0] resp_kind,
    input wire logic [7:0] resp_value,
    input wire logic       port_dplus_line,
    input wire logic       port_dplus_pulldown,
    input wire logic       port_dminus_pulldown
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // read path
    // ----------------------------------------
    a_ratio_upper_zero: assert property (rd_addr == 8'h38 |=> rd_data[7:3] == 5'h00)
        else $error("ratio register upper bits not zero");
    a_usage_not_rsvd: assert property (rd_addr == 8'h39 |=>
        rd_data[7] == 1'b0 && rd_data[2:1] != 2'h2) else $error("usage holds a reserved code");
    a_mag_not_rsvd: assert property (rd_addr == 8'h3a |=> rd_data[7:4] != 4'hf)
        else $error("magnitude holds a reserved code");
    // ----------------------------------------
    // divider ratio
    // ----------------------------------------
    a_ratio_valid_sel: assert property (ratio_valid |-> !$past(profile_bc12) &&
        $past(stim2_response_select) inside {4'h6, 4'h9, 4'hc}) else $error("ratio valid wrongly");
    a_ratio_frozen: assert property (profile_bc12 ##1 profile_bc12 ##1 profile_bc12 |=>
        $stable(ratio_out)) else $error("ratio changed under charging profile");
    a_ratio_no_rsvd: assert property (ratio_out != 3'h7)
        else $error("ratio holds reserved code");
    // ----------------------------------------
    // magnitude decode and response
    // ----------------------------------------
    a_volt_range: assert property (resp_kind == 2'h0 |-> resp_value <= 8'd22)
        else $error("voltage out of range");
    a_res_range: assert property (resp_kind == 2'h1 |->
        resp_value >= 8'd2 && resp_value <= 8'd150) else $error("resistor out of range");
    a_div_values: assert property (resp_kind == 2'h2 |->
        resp_value inside {8'd93, 8'd100, 8'd125, 8'd150, 8'd200}) else $error("bad divider");
    a_line_from_event: assert property ($rose(port_dplus_line) |->
        $past(detect_usage_a_event, 3) || $past(detect_usage_a_event, 4)) else $error("line set without event");
    a_reset_state: assert property (disable iff (1'b0) !nrst ##1 !nrst |->
        port_dplus_pulldown && port_dminus_pulldown && !port_dplus_line)
        else $error("reset state wrong");
    c_line_on: cover property ($rose(port_dplus_line));
    c_ratio_valid: cover property (ratio_valid);
    c_pd_off: cover property ($fell(port_dminus_pulldown));
endmodule
`default_nettype wire

// ===== cesc_portable_device.sv
// model of the attached portable device on the data lines
`timescale 1ns/1ps
`default_nettype none
module cesc_portable_device
(
    input  wire logic        sys_clk,
    input  wire logic        attach,
    input  wire logic        linger,
    input  wire logic        port_dplus_line,
    output logic             detect_usage_a_event,
    output logic             detect_usage_a_present,
    output logic [15:0]      high_cycles
);
    // pins move between clock edges, unrelated to the bank clock
    assign #3 detect_usage_a_event = attach;
    assign #3 detect_usage_a_present = attach | linger;
    // count cycles the response stays on the line after plug-in
    always @(posedge sys_clk)
    begin
        if (attach)
            high_cycles <= 16'h0000;
        else if (port_dplus_line)
            high_cycles <= high_cycles + 16'h0001;
    end
endmodule
`default_nettype wire

// ===== cesc_stim_config_test.sv
// self-checking bench for the stimulus config bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module cesc_stim_config_test;
    localparam int CPM = 10;
    // decode tables, code 0 in the top byte of VOLT, RES and DIV, in the low bits of KIND and RSV
    localparam logic [119:0] VOLT = 120'h000404040405060708090e10121416;
    localparam logic [119:0] RES  = 120'h020a0f14191e282b323c4b50647896;
    localparam logic [119:0] DIV  = 120'h5d647d96c8c8c8c85d647d96c8c8c8;
    localparam logic [31:0]  KIND = 32'h56086100;
    localparam logic [15:0]  RSV  = 16'h0d20;
    localparam int MS [8] = '{0, 1, 5, 10, 20, 40, 80, 100};
    int         checks, num_errors, i, c;
    logic       sys_clk, nrst, profile_load, profile_bc12, attach, linger, load_timer_kind;
    logic       ratio_valid, port_dplus_line, port_dminus_line, detect_usage_a_event, detect_usage_a_present;
    logic       port_dplus_pulldown, port_dminus_pulldown;
    logic [7:0] rd_addr, rd_data, resp_value;
    logic [2:0] load_ratio, load_time, load_usage, ratio_out;
    logic [3:0] load_select, load_magnitude, stim2_response_select;
    logic [1:0] resp_kind;
    logic [15:0] high_cycles;
    cesc_stim_config #(.CYC_PER_MS(CPM)) i_dut (.sys_clk, .nrst, .rd_addr, .rd_data,
        .profile_load, .profile_bc12, .stim2_response_select, .load_ratio, .load_timer_kind,
        .load_time, .load_usage, .load_select, .load_magnitude, .detect_usage_a_event, .detect_usage_a_present,
        .ratio_out, .ratio_valid, .resp_kind, .resp_value, .port_dplus_line, .port_dminus_line,
        .port_dplus_pulldown, .port_dminus_pulldown);
    cesc_portable_device i_dev (.sys_clk, .attach, .linger, .port_dplus_line, .detect_usage_a_event,
        .detect_usage_a_present, .high_cycles);
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic load(input logic [2:0] r, input logic k, input logic [2:0] t,
                        input logic [2:0] u, input logic [3:0] s, input logic [3:0] m);
        {load_ratio, load_timer_kind, load_time, load_usage} = {r, k, t, u};
        {load_select, load_magnitude} = {s, m};
        profile_load = 1'b1;
        tick(1);
        profile_load = 1'b0;
        tick(3);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_addr = a;
        tick(2);
        `CHK("rd_data", e, rd_data)
    endtask
    task automatic plug(input int n);
        attach = 1'b1;
        tick(2);
        attach = 1'b0;
        tick(n);
    endtask
    task automatic wrap_up;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // hang guard
    initial
    begin
        #400000;
        num_errors++;
        wrap_up();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {checks, num_errors} = '0;
        {nrst, profile_load, profile_bc12, attach, linger, load_timer_kind} = 6'h00;
        {load_ratio, load_time, load_usage, load_select, load_magnitude} = 17'h00000;
        {stim2_response_select, rd_addr} = 12'h000;
        tick(4);
        nrst = 1'b1;
        tick(3);
        rd(8'h38, 8'h00);
        rd(8'h39, 8'h00);
        rd(8'h3a, 8'h00);
        rd(8'h3b, 8'h00);
        `CHK("pulldowns", 2'h3, {port_dplus_pulldown, port_dminus_pulldown})
        load(3'h0, 1'b1, 3'h0, 3'h0, 4'he, 4'h1);
        plug(12);
        `CHK("pulldowns", 2'h3, {port_dplus_pulldown, port_dminus_pulldown})
        load(3'h0, 1'b0, 3'h1, 3'h0, 4'h1, 4'h1);
        plug(30);
        `CHK("dplus", 1'b0, port_dplus_line)
        foreach (MS[c])
        begin
            if (c == 1 || c == 3 || c == 7)
            begin
                load(3'h0, 1'b1, 3'(c), 3'h0, 4'h1, 4'h1);
                plug(MS[c] * CPM + 20);
                `CHK("hold", 1'b1, high_cycles >= MS[c] * CPM && high_cycles <= MS[c] * CPM + 6)
                `CHK("dplus", 1'b0, port_dplus_line)
            end
        end
        load(3'h0, 1'b1, 3'h1, 3'h0, 4'h3, 4'h1);
        linger = 1'b1;
        plug(40);
        `CHK("lines", 2'h3, {port_dplus_line, port_dminus_line})
        linger = 1'b0;
        tick(8);
        `CHK("lines", 2'h0, {port_dplus_line, port_dminus_line})
        linger = 1'b1;
        plug(12);
        `CHK("lines", 2'h3, {port_dplus_line, port_dminus_line})
        load(3'h0, 1'b1, 3'h1, 3'h0, 4'h0, 4'h1);
        plug(12);
        `CHK("lines", 2'h0, {port_dplus_line, port_dminus_line})
        linger = 1'b0;
        load(3'h0, 1'b1, 3'h0, 3'h7, 4'he, 4'h1);
        plug(12);
        `CHK("pulldowns", 2'h0, {port_dplus_pulldown, port_dminus_pulldown})
        load(3'h5, 1'b1, 3'h6, 3'h3, 4'hc, 4'h2);
        rd(8'h38, 8'h05);
        rd(8'h39, 8'h73);
        rd(8'h3a, 8'h2c);
        load(3'h7, 1'b0, 3'h1, 3'h4, 4'h5, 4'hf);
        rd(8'h38, 8'h05);
        rd(8'h39, 8'h0b);
        rd(8'h3a, 8'h2c);
        nrst = 1'b0;
        tick(2);
        `CHK("pulldowns", 2'h3, {port_dplus_pulldown, port_dminus_pulldown})
        nrst = 1'b1;
        tick(3);
        rd(8'h38, 8'h00);
        rd(8'h39, 8'h00);
        rd(8'h3a, 8'h00);
        stim2_response_select = 4'h6;
        for (i = 0; i < 7; i++)
        begin
            load(3'(i), 1'b0, 3'h0, 3'h0, 4'h0, 4'h0);
            `CHK("ratio", 3'(i), ratio_out)
        end
        for (i = 0; i < 16; i++)
        begin
            stim2_response_select = 4'(i);
            tick(2);
            `CHK("ratio_valid", (i == 6 || i == 9 || i == 12), ratio_valid)
        end
        stim2_response_select = 4'h6;
        profile_bc12 = 1'b1;
        tick(2);
        `CHK("ratio_valid", 1'b0, ratio_valid)
        load(3'h2, 1'b0, 3'h0, 3'h0, 4'h0, 4'h0);
        `CHK("ratio", 3'h6, ratio_out)
        profile_bc12 = 1'b0;
        for (i = 0; i < 16; i++)
        begin
            if (!RSV[i])
            begin
                load(3'h0, 1'b0, 3'h0, 3'h0, 4'(i), 4'h1);
                `CHK("resp_kind", KIND[i*2+:2], resp_kind)
            end
        end
        for (i = 0; i < 15; i++)
        begin
            load(3'h0, 1'b0, 3'h0, 3'h0, 4'h3, 4'(i));
            `CHK("volt", VOLT[(14-i)*8+:8], resp_value)
            load(3'h0, 1'b0, 3'h0, 3'h0, 4'h4, 4'(i));
            `CHK("res", RES[(14-i)*8+:8], resp_value)
            load(3'h0, 1'b0, 3'h0, 3'h0, 4'h6, 4'(i));
            `CHK("div", DIV[(14-i)*8+:8], resp_value)
        end
        wrap_up();
    end
endmodule
bind cesc_stim_config cesc_stim_config_assertions #(.CYC_PER_MS(CYC_PER_MS)) i_chk (.sys_clk,
    .nrst, .rd_addr, .rd_data, .profile_bc12, .stim2_response_select, .detect_usage_a_event, .ratio_out,
    .ratio_valid, .resp_kind, .resp_value, .port_dplus_line, .port_dplus_pulldown,
    .port_dminus_pulldown);
`default_nettype wire
